//--- rtl/mdfm_top.sv
// Fault and operating-mode manager of the H-bridge driver
`timescale 1ns/1ps
module mdfm_top #(
   parameter int unsigned RETRY_CYC = mdfm_pkg::RETRY_INTERVAL_CYC,
   parameter int unsigned SLEEP_CYC = mdfm_pkg::SLEEP_ENTRY_CYC,
   parameter int unsigned DEGLITCH_CYC = mdfm_pkg::OC_DEGLITCH_CYC,
   parameter int unsigned WAKE_CYC = mdfm_pkg::WAKE_DELAY_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic supply_low_i,
   input wire logic sleep_pin_n_i,
   input wire logic [3:0] fet_limit_i,
   input wire logic [3:0] bridge_drive_i,
   input wire logic overtemp_i,
   input wire logic overtemp_cool_i,
   input wire logic backdrive_high_i,
   input wire logic brake_overcurrent_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [3:0] gate_o,
   output logic error_indicator_pin_n_o,
   output logic error_indicator_pin_n_oe_n_o,
   output logic active_mode_o,
   output logic sleep_mode_o,
   output logic fault_mode_o,
   output logic internal_enable_o
);
   localparam int unsigned RW = $clog2(RETRY_CYC + 1);

   mdfm_pkg::mdfm_state_t state_reg, state_next;
   logic lockout;
   logic logic_rst;
   logic [3:0] fet_trip;
   logic oc_trip;
   logic sleep_done;
   logic wake_done;
   logic [5:0] idx;
   logic [7:0] wr_data;
   logic wr;
   logic [7:0] rd_data;
   logic clr_pulse;
   logic bridge_en_reg;
   logic bd_en_reg;
   logic oc_sel_reg;
   logic th_sel_reg;
   logic oc_hold_reg;
   logic oc_flag_reg;
   logic ot_hold_reg;
   logic ot_flag_reg;
   logic marker_reg;
   logic [RW-1:0] retry_reg;
   logic brake_stop_reg;
   logic brake_next;
   logic brake_reg;
   logic bd_flag_reg;
   logic any_error_reg;
   logic fault_hold;
   logic [3:0] gate_reg;
   logic pin_oe_n_reg;
   logic pin_out_reg;
   logic active_reg;
   logic sleep_reg;
   logic fault_reg;
   logic internal_reg;

   assign lockout = rst_i || supply_low_i;
   assign logic_rst = lockout || (state_reg == mdfm_pkg::ST_SLEEP);
   assign fault_hold = oc_hold_reg || ot_hold_reg;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   mdfm_wb_slave u_wb (
      .clk_i(clk_i),
      .rst_i(lockout),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .rd_data_i(rd_data),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .idx_o(idx),
      .wr_data_o(wr_data),
      .wr_o(wr)
   );

   assign clr_pulse = wr && (idx == mdfm_pkg::IDX_CONTROL)
      && wr_data[mdfm_pkg::BIT_CLEAR];

   always_comb begin
      rd_data = 8'h00;
      case (idx)
         mdfm_pkg::IDX_FAULT_STATUS: begin
            rd_data[mdfm_pkg::BIT_ANY_ERROR] = any_error_reg;
            rd_data[mdfm_pkg::BIT_OC_FLAG] = oc_flag_reg;
            rd_data[mdfm_pkg::BIT_BD_FLAG] = bd_flag_reg;
            rd_data[mdfm_pkg::BIT_OT_FLAG] = ot_flag_reg;
            rd_data[mdfm_pkg::BIT_POWER_ON] = marker_reg;
         end
         mdfm_pkg::IDX_CONTROL: begin
            rd_data[mdfm_pkg::BIT_BRIDGE_EN] = bridge_en_reg;
            rd_data[mdfm_pkg::BIT_BD_EN] = bd_en_reg;
         end
         mdfm_pkg::IDX_RESPONSE: begin
            rd_data[mdfm_pkg::BIT_OC_SEL] = oc_sel_reg;
            rd_data[mdfm_pkg::BIT_TH_SEL] = th_sel_reg;
         end
         default: begin
            rd_data = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Configuration bits
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         bridge_en_reg <= mdfm_pkg::RST_BRIDGE_EN;
         oc_sel_reg <= mdfm_pkg::RST_OC_SEL;
         th_sel_reg <= mdfm_pkg::RST_TH_SEL;
      end else if (wr && idx == mdfm_pkg::IDX_CONTROL) begin
         bridge_en_reg <= wr_data[mdfm_pkg::BIT_BRIDGE_EN];
      end else if (wr && idx == mdfm_pkg::IDX_RESPONSE) begin
         oc_sel_reg <= wr_data[mdfm_pkg::BIT_OC_SEL];
         th_sel_reg <= wr_data[mdfm_pkg::BIT_TH_SEL];
      end
   end

   // Back-drive enable survives sleep, only lockout restores it
   always_ff @(posedge clk_i) begin
      if (lockout) begin
         bd_en_reg <= mdfm_pkg::RST_BD_EN;
      end else if (wr && idx == mdfm_pkg::IDX_CONTROL) begin
         bd_en_reg <= wr_data[mdfm_pkg::BIT_BD_EN];
      end
   end

   // ----------------------------------------------------------------
   // Sleep and wake qualification
   // ----------------------------------------------------------------
   mdfm_qualify #(.LIMIT(SLEEP_CYC)) u_sleep_q (
      .clk_i(clk_i),
      .rst_i(lockout),
      .cond_i(!sleep_pin_n_i),
      .done_o(sleep_done)
   );

   mdfm_qualify #(.LIMIT(WAKE_CYC)) u_wake_q (
      .clk_i(clk_i),
      .rst_i(lockout),
      .cond_i(sleep_pin_n_i),
      .done_o(wake_done)
   );

   // ----------------------------------------------------------------
   // Overcurrent: one deglitch filter per FET
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_fet
      mdfm_qualify #(.LIMIT(DEGLITCH_CYC)) u_oc_q (
         .clk_i(clk_i),
         .rst_i(logic_rst),
         .cond_i(fet_limit_i[g]),
         .done_o(fet_trip[g])
      );
   end
   assign oc_trip = |fet_trip;

   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         oc_hold_reg <= 1'b0;
         retry_reg <= '0;
      end else if (oc_trip && !oc_hold_reg) begin
         oc_hold_reg <= 1'b1;
         retry_reg <= RW'(RETRY_CYC - 1);
      end else if (oc_hold_reg && oc_sel_reg) begin
         if (retry_reg == '0) begin
            oc_hold_reg <= 1'b0;
         end else begin
            retry_reg <= retry_reg - RW'(1);
         end
      end else if (oc_hold_reg && clr_pulse) begin
         oc_hold_reg <= 1'b0;
      end
   end

   // Hardware set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         oc_flag_reg <= 1'b0;
      end else if (oc_trip) begin
         oc_flag_reg <= 1'b1;
      end else if (clr_pulse) begin
         oc_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Thermal shutdown
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         ot_hold_reg <= 1'b0;
      end else if (overtemp_i) begin
         ot_hold_reg <= 1'b1;
      end else if (th_sel_reg && overtemp_cool_i) begin
         ot_hold_reg <= 1'b0;
      end else if (!th_sel_reg && clr_pulse) begin
         ot_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (logic_rst) begin
         ot_flag_reg <= 1'b0;
      end else if (overtemp_i) begin
         ot_flag_reg <= 1'b1;
      end else if (clr_pulse) begin
         ot_flag_reg <= 1'b0;
      end
   end

   // Marker low from lockout release until the first clear
   always_ff @(posedge clk_i) begin
      if (lockout) begin
         marker_reg <= 1'b0;
      end else if (clr_pulse) begin
         marker_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mdfm_pkg::ST_SLEEP: begin
            if (wake_done) begin
               state_next = mdfm_pkg::ST_STANDBY;
            end
         end
         mdfm_pkg::ST_STANDBY, mdfm_pkg::ST_ACTIVE: begin
            if (fault_hold) begin
               state_next = mdfm_pkg::ST_FAULT;
            end else if (bridge_en_reg) begin
               state_next = mdfm_pkg::ST_ACTIVE;
            end else begin
               state_next = mdfm_pkg::ST_STANDBY;
            end
         end
         mdfm_pkg::ST_FAULT: begin
            if (!fault_hold) begin
               state_next = mdfm_pkg::ST_STANDBY;
            end
         end
         default: begin
            state_next = mdfm_pkg::ST_SLEEP;
         end
      endcase
      if (sleep_done) begin
         state_next = mdfm_pkg::ST_SLEEP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (lockout) begin
         state_reg <= mdfm_pkg::ST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Back-drive braking
   // ----------------------------------------------------------------
   assign brake_next = !lockout && bd_en_reg && backdrive_high_i
      && !brake_stop_reg
      && (state_next != mdfm_pkg::ST_ACTIVE);

   // High-current stop holds until the back-drive ends
   always_ff @(posedge clk_i) begin
      if (lockout || !backdrive_high_i) begin
         brake_stop_reg <= 1'b0;
      end else if (brake_reg && brake_overcurrent_i) begin
         brake_stop_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (lockout) begin
         gate_reg <= mdfm_pkg::GATES_OFF;
         brake_reg <= 1'b0;
         bd_flag_reg <= 1'b0;
      end else begin
         brake_reg <= brake_next;
         bd_flag_reg <= brake_next
            && (state_next != mdfm_pkg::ST_SLEEP);
         if (brake_next) begin
            gate_reg <= mdfm_pkg::GATES_BRAKE;
         end else if (state_next == mdfm_pkg::ST_ACTIVE && !oc_trip) begin
            gate_reg <= bridge_drive_i;
         end else begin
            gate_reg <= mdfm_pkg::GATES_OFF;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (lockout) begin
         any_error_reg <= 1'b0;
         pin_oe_n_reg <= 1'b0;
      end else begin
         any_error_reg <= (state_next == mdfm_pkg::ST_FAULT);
         pin_oe_n_reg <= (state_next != mdfm_pkg::ST_FAULT);
      end
   end

   // Open-drain: the driven level is always low
   always_ff @(posedge clk_i) begin
      if (lockout) begin
         pin_out_reg <= 1'b0;
      end else begin
         pin_out_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (lockout) begin
         active_reg <= 1'b0;
         sleep_reg <= 1'b1;
         fault_reg <= 1'b0;
         internal_reg <= 1'b0;
      end else begin
         active_reg <= (state_next == mdfm_pkg::ST_ACTIVE);
         sleep_reg <= (state_next == mdfm_pkg::ST_SLEEP);
         fault_reg <= (state_next == mdfm_pkg::ST_FAULT);
         internal_reg <= (state_next != mdfm_pkg::ST_SLEEP)
            && !brake_next;
      end
   end

   assign gate_o = gate_reg;
   assign error_indicator_pin_n_o = pin_out_reg;
   assign error_indicator_pin_n_oe_n_o = pin_oe_n_reg;
   assign active_mode_o = active_reg;
   assign sleep_mode_o = sleep_reg;
   assign fault_mode_o = fault_reg;
   assign internal_enable_o = internal_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (lockout);

   a_oc_trip_off: assert property (oc_trip && !logic_rst && !sleep_done
      |=> gate_reg[0] == 1'b0 && gate_reg[2] == 1'b0)
      else $error("high sides on after overcurrent trip");
   a_oc_flag_set: assert property (oc_trip && !logic_rst
      |=> oc_flag_reg)
      else $error("overcurrent flag not set");
   a_oc_latch_hold: assert property (oc_hold_reg && !oc_sel_reg
      && !clr_pulse && !logic_rst |=> oc_hold_reg)
      else $error("latched overcurrent released without clear");
   a_oc_retry_len: assert property (oc_hold_reg && oc_sel_reg
      && retry_reg != '0 && !logic_rst |=> oc_hold_reg)
      else $error("retry hold ended early");
   a_ot_shutdown: assert property (overtemp_i && !logic_rst
      |=> ot_flag_reg && ot_hold_reg)
      else $error("overtemperature not latched");
   a_ot_auto_end: assert property (ot_hold_reg && th_sel_reg
      && overtemp_cool_i && !overtemp_i && !logic_rst
      |=> !ot_hold_reg)
      else $error("automatic thermal recovery missed");
   a_marker_clear: assert property (clr_pulse |=> marker_reg)
      else $error("power-on marker not set by clear");
   a_brake_lows: assert property (brake_reg
      |-> gate_reg == mdfm_pkg::GATES_BRAKE)
      else $error("braking without both low sides");
   a_pin_error: assert property (any_error_reg
      |-> !error_indicator_pin_n_oe_n_o)
      else $error("error pin released during fault");
   a_sleep_hiz: assert property (sleep_mode_o && !brake_reg
      |-> gate_reg == mdfm_pkg::GATES_OFF)
      else $error("gates driven in sleep");

   c_oc_trip: cover property (oc_trip ##1 oc_hold_reg);
   c_ot_auto: cover property (ot_hold_reg && th_sel_reg ##1 !ot_hold_reg);
   c_brake: cover property (brake_reg);
   c_active: cover property (active_mode_o);

endmodule : mdfm_top

//--- common/mdfm_pkg.sv
// Constants and types of the motor driver fault manager
package mdfm_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned OC_DEGLITCH_NS = 2000;
   localparam int unsigned WAKE_DELAY_NS = 100000;
   localparam int unsigned RETRY_INTERVAL_NS = 4000000;
   localparam int unsigned SLEEP_ENTRY_NS = 1000000;
   localparam int unsigned OC_DEGLITCH_CYC =
      (OC_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WAKE_DELAY_CYC =
      (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RETRY_INTERVAL_CYC =
      (RETRY_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_ENTRY_CYC =
      (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_FAULT_STATUS = 6'h00;
   localparam logic [5:0] IDX_CONTROL = 6'h09;
   localparam logic [5:0] IDX_RESPONSE = 6'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_ANY_ERROR = 7;
   localparam int unsigned BIT_OC_FLAG = 4;
   localparam int unsigned BIT_BD_FLAG = 3;
   localparam int unsigned BIT_OT_FLAG = 2;
   localparam int unsigned BIT_POWER_ON = 1;
   localparam int unsigned BIT_BRIDGE_EN = 7;
   localparam int unsigned BIT_BD_EN = 6;
   localparam int unsigned BIT_CLEAR = 1;
   localparam int unsigned BIT_OC_SEL = 1;
   localparam int unsigned BIT_TH_SEL = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_BRIDGE_EN = 1'b0;
   localparam logic RST_BD_EN = 1'b1;
   localparam logic RST_OC_SEL = 1'b0;
   localparam logic RST_TH_SEL = 1'b0;

   // ----------------------------------------------------------------
   // Gate order: high A, low A, high B, low B
   // ----------------------------------------------------------------
   localparam logic [3:0] GATES_OFF = 4'h0;
   localparam logic [3:0] GATES_BRAKE = 4'ha;

   typedef enum logic [1:0] {
      ST_SLEEP,
      ST_STANDBY,
      ST_ACTIVE,
      ST_FAULT
   } mdfm_state_t;

endpackage : mdfm_pkg

//--- rtl/mdfm_qualify.sv
// Level qualifier: reports a condition held for a number of cycles
`timescale 1ns/1ps
module mdfm_qualify #(
   parameter int unsigned LIMIT = 4,
   parameter int unsigned W = $clog2(LIMIT + 1)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cond_i,
   output logic done_o
);
   logic [W-1:0] cnt_reg;

   // ----------------------------------------------------------------
   // Saturating hold counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !cond_i) begin
         cnt_reg <= '0;
      end else if (cnt_reg != W'(LIMIT)) begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end

   assign done_o = (cnt_reg == W'(LIMIT));

endmodule : mdfm_qualify

//--- rtl/mdfm_wb_slave.sv
// Classic Wishbone slave front end for the byte-wide registers
`timescale 1ns/1ps
module mdfm_wb_slave (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [7:0] rd_data_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [5:0] idx_o,
   output logic [7:0] wr_data_o,
   output logic wr_o
);
   logic ack_reg;
   logic [31:0] dat_reg;

   // ----------------------------------------------------------------
   // One wait state, ack for one cycle, data latched with it
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
         if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            dat_reg <= {24'h00_0000, rd_data_i};
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign idx_o = wb_adr_i[7:2];
   assign wr_data_o = wb_dat_i[7:0];
   // Write lands on the edge where the master samples ack
   assign wr_o = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && ack_reg;

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule : mdfm_wb_slave

//--- tb/mdfm_host.sv
// Host model: Wishbone master and sleep pin driver
`timescale 1ns/1ps
module mdfm_host (
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o = 1'b0,
   output logic stb_o = 1'b0,
   output logic we_o = 1'b0,
   output logic [7:0] adr_o = 8'h00,
   output logic [3:0] sel_o = 4'h0,
   output logic [31:0] dat_o = 32'h00000000,
   output logic sleep_n_o = 1'b0
);
   // One classic cycle, held until ack; a clear is one write
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'h1;
      dat_o <= {24'h000000, d};
      @(posedge clk_i);
      while (ack_i !== 1'b1) begin
         @(posedge clk_i);
      end
      q = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      @(posedge clk_i);
   endtask : xfer
   // Sleep pin level; back-drive enable is written by xfer
   task automatic set_sleep_n(input logic v);
      sleep_n_o <= v;
   endtask : set_sleep_n
endmodule : mdfm_host

//--- tb/mdfm_top_test.sv
// Testbench of the motor driver fault manager
`timescale 1ns/1ps
module mdfm_top_test;
   localparam int unsigned RC = 20;
   localparam int unsigned SC = 10;
   localparam int unsigned DC = 4;
   localparam int unsigned WC = 4;
   logic clk, rst, sup, cyc, stb, we, ack, ot, cool, bd, bd_oc;
   logic pin, oe_n, act, slp, flt, ien, sl_n;
   logic [7:0] adr, q;
   logic [3:0] sel, lim, drv, gate;
   logic [31:0] wdat, rdat;
   int error_cnt = 0;
   int total_checks = 0;
   wire logic line = oe_n ? 1'b1 : pin;
   mdfm_top #(.RETRY_CYC(RC), .SLEEP_CYC(SC), .DEGLITCH_CYC(DC),
      .WAKE_CYC(WC)) mdfm_top_inst (.clk_i(clk), .rst_i(rst),
      .supply_low_i(sup), .sleep_pin_n_i(sl_n), .fet_limit_i(lim),
      .bridge_drive_i(drv), .overtemp_i(ot), .overtemp_cool_i(cool),
      .backdrive_high_i(bd), .brake_overcurrent_i(bd_oc), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .gate_o(gate),
      .error_indicator_pin_n_o(pin), .error_indicator_pin_n_oe_n_o(oe_n),
      .active_mode_o(act), .sleep_mode_o(slp), .fault_mode_o(flt),
      .internal_enable_o(ien));
   mdfm_host mdfm_host_inst (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
      .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wdat), .sleep_n_o(sl_n));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      mdfm_host_inst.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      mdfm_host_inst.xfer(1'b0, a, 8'h00, q);
   endtask : rd
   task automatic close_out;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_wake;
      mdfm_host_inst.set_sleep_n(1'b1);
      tick(WC + 4);
      wr(8'h24, 8'hc0);
      tick(2);
      chk(act, 1'b1);
      chk(gate, 4'h5);
   endtask : t_wake
   task automatic t_oc(input int i);
      lim <= 4'h1 << i;
      tick(DC + 5);
      chk(gate, 4'h0);
      chk(line, 1'b0);
      chk({flt, ien}, 2'b11);
      rd(8'h00);
      chk(q, 8'h92);
      lim <= 4'h0;
      tick(RC + 5);
      chk(gate, 4'h0);
      wr(8'h24, 8'hc2);
      tick(2);
      chk(line, 1'b1);
      chk(gate, 4'h5);
   endtask : t_oc
   task automatic t_retry;
      wr(8'h30, 8'h02);
      lim <= 4'h8;
      tick(DC + 5);
      lim <= 4'h0;
      chk({gate, line}, 5'h00);
      tick(RC + 5);
      chk({gate, line}, 5'h0b);
      rd(8'h00);
      chk(q, 8'h12);
      wr(8'h24, 8'hc2);
   endtask : t_retry
   task automatic t_therm;
      wr(8'h30, 8'h01);
      ot <= 1'b1;
      cool <= 1'b0;
      tick(4);
      chk(gate, 4'h0);
      rd(8'h00);
      chk(q, 8'h86);
      ot <= 1'b0;
      tick(4);
      chk(gate, 4'h0);
      cool <= 1'b1;
      tick(4);
      chk({gate, line}, 5'h0b);
      rd(8'h00);
      chk(q, 8'h06);
      wr(8'h30, 8'h00);
      ot <= 1'b1;
      cool <= 1'b0;
      tick(4);
      ot <= 1'b0;
      cool <= 1'b1;
      tick(4);
      chk(gate, 4'h0);
      wr(8'h24, 8'hc2);
      tick(3);
      chk(gate, 4'h5);
   endtask : t_therm
   task automatic t_bd;
      mdfm_host_inst.set_sleep_n(1'b0);
      tick(SC + 5);
      chk({slp, gate}, 5'h10);
      chk({act, ien}, 2'b00);
      bd <= 1'b1;
      tick(3);
      chk(gate, 4'ha);
      chk(line, 1'b1);
      bd_oc <= 1'b1;
      tick(3);
      chk(gate, 4'h0);
      bd_oc <= 1'b0;
      bd <= 1'b0;
      tick(3);
      chk(gate, 4'h0);
      t_wake;
      wr(8'h24, 8'h40);
      bd <= 1'b1;
      tick(3);
      chk({gate, ien}, 5'h14);
      rd(8'h00);
      chk(q, 8'h0a);
      bd <= 1'b0;
      tick(2);
      wr(8'h24, 8'h80);
      mdfm_host_inst.set_sleep_n(1'b0);
      tick(SC + 5);
      bd <= 1'b1;
      tick(3);
      chk(gate, 4'h0);
      bd <= 1'b0;
   endtask : t_bd
   task automatic t_uv;
      sup <= 1'b1;
      tick(3);
      chk({line, gate}, 5'h00);
      sup <= 1'b0;
      tick(3);
      chk(line, 1'b1);
      t_wake;
      rd(8'h00);
      chk(q, 8'h00);
   endtask : t_uv
   // ------------------------------------------------------------
   // Main sequence, clock and watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      tick(20000);
      error_cnt++;
      close_out;
   end
   initial begin
      rst = 1'b1;
      sup = 1'b0;
      lim = 4'h0;
      drv = 4'h5;
      ot = 1'b0;
      cool = 1'b1;
      bd = 1'b0;
      bd_oc = 1'b0;
      tick(5);
      rst <= 1'b0;
      tick(2);
      chk(line, 1'b1);
      t_wake;
      rd(8'h00);
      chk(q, 8'h00);
      rd(8'hfc);
      chk(q, 8'h00);
      wr(8'h24, 8'hc2);
      rd(8'h00);
      chk(q, 8'h02);
      for (int i = 0; i < 4; i++) begin
         t_oc(i);
      end
      t_retry;
      t_therm;
      t_bd;
      t_uv;
      close_out;
   end
endmodule : mdfm_top_test
